// File: hw/ecl_defines.svh
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH

// configuration and status register addresses
`define ECL_ADDR_CTRL 8'ha0
`define ECL_ADDR_INTEG_FLOOR 8'ha8
`define ECL_ADDR_GAIN_FLOOR 8'ha9
`define ECL_ADDR_INTEG_CEIL 8'haa
`define ECL_ADDR_GAIN_CEIL 8'hab
`define ECL_ADDR_PIX_COUNT 8'hb8
`define ECL_ADDR_MEAN 8'hba
`define ECL_ADDR_LOOP_INTEG 8'hbb
`define ECL_ADDR_LOOP_GAIN 8'hbc
`define ECL_ADDR_MANUAL_INTEG 8'hc9
`define ECL_ADDR_LATENCY 8'hcc
`define ECL_ADDR_APP_GRAN 8'hd0
`define ECL_ADDR_APP_CLEAR 8'hd1
`define ECL_ADDR_APP_INTEG 8'hd2
`define ECL_ADDR_APP_SLOPE2 8'hd3
`define ECL_ADDR_APP_SLOPE3 8'hd4
`define ECL_ADDR_APP_ANALOG 8'hd5
`define ECL_ADDR_APP_FINE 8'hd6

// bit positions
`define ECL_BIT_ENABLE 0
`define ECL_BIT_AMP_PRI 1
`define ECL_BIT_LAT_COMP 13
`define ECL_BIT_DUAL 12
`define ECL_BIT_TRIPLE 13
`define ECL_FINE_FRAC 7
`define ECL_S1_MSB 1
`define ECL_S1_LSB 0
`define ECL_S2_MSB 3
`define ECL_S2_LSB 2
`define ECL_FINE_MSB 15
`define ECL_FINE_LSB 4

// reset values
`define ECL_RST_INTEG_FLOOR 16'h0001
`define ECL_RST_INTEG_CEIL 16'h03ff
`define ECL_RST_GAIN_FLOOR 16'h0800
`define ECL_RST_GAIN_CEIL 16'h200d
`define ECL_RST_MANUAL_INTEG 16'h0100
`define ECL_RST_FINE 12'h080

// loop step sizes and pixel saturation value
`define ECL_INTEG_STEP 16'h0001
`define ECL_FINE_STEP 16'h0008
`define ECL_PIX_MAX 10'h3ff

`endif

// File: hw/ecl_pkg.sv
package ecl_pkg;

    // which parameter the loop moves in one evaluation
    typedef enum logic [2:0] {
        ECL_STEP_NONE,
        ECL_STEP_INTEG,
        ECL_STEP_STAGE1,
        ECL_STEP_STAGE2,
        ECL_STEP_FINE
    } ecl_step_t;

endpackage : ecl_pkg

// File: hw/ecl_limits_status.sv
`timescale 1ns/1ns
`include "ecl_defines.svh"
module ecl_limits_status
    import ecl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    input wire logic frame_end,
    input wire logic frame_start,
    input wire logic gain_up,
    input wire logic gain_down,
    input wire logic stat_valid,
    input wire logic [15:0] stat_pixel_count,
    input wire logic [9:0] stat_mean,
    input wire logic global_shutter,
    input wire logic [15:0] seq_step_gran,
    input wire logic [15:0] seq_clear_len,
    input wire logic [15:0] second_slope_time,
    input wire logic [15:0] third_slope_time,
    input wire logic seq_dual_en,
    input wire logic seq_triple_en,
    input wire logic [9:0] pix_in,
    input wire logic pix_in_valid,
    output logic [9:0] pix_out_q,
    output logic pix_out_valid_q,
    output logic [15:0] req_integ_q,
    output logic [1:0] amp1_gain_q,
    output logic [1:0] amp2_gain_q
);

    // field decoders shared by the floor and ceiling registers
    function automatic logic [1:0] fld_stage1(input logic [15:0] r);
        fld_stage1 = r[`ECL_S1_MSB:`ECL_S1_LSB];
    endfunction : fld_stage1

    function automatic logic [1:0] fld_stage2(input logic [15:0] r);
        fld_stage2 = r[`ECL_S2_MSB:`ECL_S2_LSB];
    endfunction : fld_stage2

    function automatic logic [11:0] fld_fine(input logic [15:0] r);
        fld_fine = r[`ECL_FINE_MSB:`ECL_FINE_LSB];
    endfunction : fld_fine

    // floor first then ceiling, so a ceiling always holds
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] t;
        t = (v < lo) ? lo : v;
        clamp16 = (t > hi) ? hi : t;
    endfunction : clamp16

    logic [15:0] integ_floor_q, integ_ceil_q, gain_floor_q, gain_ceil_q, manual_integ_q;
    logic aec_en_q, amp_pri_q, lat_comp_q;
    logic [15:0] pix_count_q;
    logic [9:0] mean_q;
    logic [15:0] loop_integ_q;
    logic [1:0] loop_s1_q, loop_s2_q;
    logic [11:0] loop_fine_q;
    logic [1:0] pend_s1_q, pend_s2_q;
    logic [11:0] pend_fine_q;
    logic [15:0] pend_integ_q;
    logic [15:0] app_integ_q, app_gran_q, app_clear_q, app_slope2_q, app_slope3_q;
    logic [1:0] app_s1_q, app_s2_q;
    logic [11:0] app_fine_q;
    logic app_dual_q, app_triple_q;
    logic phase_q, fired_last_q;
    logic eval_fire;
    ecl_step_t step;
    logic [15:0] n_integ, n_s1, n_s2, n_fine;
    logic [15:0] c_integ, c_s1, c_s2, c_fine;
    logic [21:0] prod;

    // only every second frame end evaluates
    assign eval_fire = frame_end && phase_q && aec_en_q;

    // configuration writes; status addresses are not decoded here
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            integ_floor_q <= `ECL_RST_INTEG_FLOOR;
            integ_ceil_q <= `ECL_RST_INTEG_CEIL;
            gain_floor_q <= `ECL_RST_GAIN_FLOOR;
            gain_ceil_q <= `ECL_RST_GAIN_CEIL;
            manual_integ_q <= `ECL_RST_MANUAL_INTEG;
            aec_en_q <= 1'b0;
            amp_pri_q <= 1'b0;
            lat_comp_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `ECL_ADDR_INTEG_FLOOR: integ_floor_q <= reg_wdata;
                `ECL_ADDR_INTEG_CEIL: integ_ceil_q <= reg_wdata;
                `ECL_ADDR_GAIN_FLOOR: gain_floor_q <= reg_wdata;
                `ECL_ADDR_GAIN_CEIL: gain_ceil_q <= reg_wdata;
                `ECL_ADDR_MANUAL_INTEG: manual_integ_q <= reg_wdata;
                `ECL_ADDR_CTRL:
                begin
                    aec_en_q <= reg_wdata[`ECL_BIT_ENABLE];
                    amp_pri_q <= reg_wdata[`ECL_BIT_AMP_PRI];
                end
                `ECL_ADDR_LATENCY: lat_comp_q <= reg_wdata[`ECL_BIT_LAT_COMP];
                default: ;
            endcase
        end
    end

    // register reads; unmapped addresses answer zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata_q <= 16'h0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `ECL_ADDR_CTRL: reg_rdata_q <= {14'h0000, amp_pri_q, aec_en_q};
                `ECL_ADDR_INTEG_FLOOR: reg_rdata_q <= integ_floor_q;
                `ECL_ADDR_GAIN_FLOOR: reg_rdata_q <= gain_floor_q;
                `ECL_ADDR_INTEG_CEIL: reg_rdata_q <= integ_ceil_q;
                `ECL_ADDR_GAIN_CEIL: reg_rdata_q <= gain_ceil_q;
                `ECL_ADDR_MANUAL_INTEG: reg_rdata_q <= manual_integ_q;
                `ECL_ADDR_LATENCY: reg_rdata_q <= {2'b00, lat_comp_q, 13'h0000};
                `ECL_ADDR_PIX_COUNT: reg_rdata_q <= pix_count_q;
                `ECL_ADDR_MEAN: reg_rdata_q <= {6'h00, mean_q};
                `ECL_ADDR_LOOP_INTEG: reg_rdata_q <= loop_integ_q;
                `ECL_ADDR_LOOP_GAIN: reg_rdata_q <= {loop_fine_q, loop_s2_q, loop_s1_q};
                `ECL_ADDR_APP_GRAN: reg_rdata_q <= app_gran_q;
                `ECL_ADDR_APP_CLEAR: reg_rdata_q <= app_clear_q;
                `ECL_ADDR_APP_INTEG: reg_rdata_q <= app_integ_q;
                `ECL_ADDR_APP_SLOPE2: reg_rdata_q <= app_slope2_q;
                `ECL_ADDR_APP_SLOPE3: reg_rdata_q <= app_slope3_q;
                `ECL_ADDR_APP_ANALOG: reg_rdata_q <= {3'h0, 6'h00, app_s2_q, 3'h0, app_s1_q};
                `ECL_ADDR_APP_FINE: reg_rdata_q <= {2'b00, app_triple_q, app_dual_q, app_fine_q};
                default: reg_rdata_q <= 16'h0000;
            endcase
        end
    end

    // frame phase: toggles each frame end to halve the update rate
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase_q <= 1'b0;
            fired_last_q <= 1'b0;
        end
        else if (frame_end)
        begin
            phase_q <= ~phase_q;
            fired_last_q <= eval_fire;
        end
    end

    // statistics capture from the statistics block
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pix_count_q <= 16'h0000;
            mean_q <= 10'h000;
        end
        else if (stat_valid)
        begin
            pix_count_q <= stat_pixel_count;
            mean_q <= stat_mean;
        end
    end

    // pick one parameter to move; integration is the coarsest lever
    always_comb
    begin
        step = ECL_STEP_NONE;
        if (gain_up && !gain_down)
        begin
            if (loop_integ_q < integ_ceil_q)
                step = ECL_STEP_INTEG;
            else if (!amp_pri_q && loop_s1_q < fld_stage1(gain_ceil_q))
                step = ECL_STEP_STAGE1;
            else if (loop_s2_q < fld_stage2(gain_ceil_q))
                step = ECL_STEP_STAGE2;
            else if (amp_pri_q && loop_s1_q < fld_stage1(gain_ceil_q))
                step = ECL_STEP_STAGE1;
            else if (loop_fine_q < fld_fine(gain_ceil_q))
                step = ECL_STEP_FINE;
        end
        else if (gain_down && !gain_up)
        begin
            // going down unwinds in reverse order
            if (loop_fine_q > fld_fine(gain_floor_q))
                step = ECL_STEP_FINE;
            else if (amp_pri_q && loop_s1_q > fld_stage1(gain_floor_q))
                step = ECL_STEP_STAGE1;
            else if (loop_s2_q > fld_stage2(gain_floor_q))
                step = ECL_STEP_STAGE2;
            else if (!amp_pri_q && loop_s1_q > fld_stage1(gain_floor_q))
                step = ECL_STEP_STAGE1;
            else if (loop_integ_q > integ_floor_q)
                step = ECL_STEP_INTEG;
        end
    end

    // apply the chosen step, then clamp everything to the live bounds
    always_comb
    begin
        n_integ = loop_integ_q;
        n_s1 = {14'h0000, loop_s1_q};
        n_s2 = {14'h0000, loop_s2_q};
        n_fine = {4'h0, loop_fine_q};
        unique case (step)
            ECL_STEP_NONE: ;
            ECL_STEP_INTEG: n_integ = gain_up ? loop_integ_q + `ECL_INTEG_STEP : loop_integ_q - `ECL_INTEG_STEP;
            ECL_STEP_STAGE1: n_s1 = gain_up ? n_s1 + 16'h0001 : n_s1 - 16'h0001;
            ECL_STEP_STAGE2: n_s2 = gain_up ? n_s2 + 16'h0001 : n_s2 - 16'h0001;
            ECL_STEP_FINE:
            begin
                if (gain_up)
                    n_fine = n_fine + `ECL_FINE_STEP;
                else
                    n_fine = (n_fine >= `ECL_FINE_STEP) ? n_fine - `ECL_FINE_STEP : 16'h0000;
            end
        endcase
        c_integ = clamp16(n_integ, integ_floor_q, integ_ceil_q);
        c_s1 = clamp16(n_s1, {14'h0000, fld_stage1(gain_floor_q)}, {14'h0000, fld_stage1(gain_ceil_q)});
        c_s2 = clamp16(n_s2, {14'h0000, fld_stage2(gain_floor_q)}, {14'h0000, fld_stage2(gain_ceil_q)});
        c_fine = clamp16(n_fine, {4'h0, fld_fine(gain_floor_q)}, {4'h0, fld_fine(gain_ceil_q)});
    end

    // loop-side results, taken at the evaluating frame end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            loop_integ_q <= `ECL_RST_INTEG_FLOOR;
            loop_s1_q <= 2'b00;
            loop_s2_q <= 2'b00;
            loop_fine_q <= `ECL_RST_FINE;
        end
        else if (eval_fire)
        begin
            loop_integ_q <= c_integ;
            loop_s1_q <= c_s1[1:0];
            loop_s2_q <= c_s2[1:0];
            loop_fine_q <= c_fine[11:0];
        end
    end

    // hand-off to the sequencer; manual time stands in while the loop is off
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            req_integ_q <= `ECL_RST_MANUAL_INTEG;
        else if (!aec_en_q)
            req_integ_q <= manual_integ_q;
        else if (eval_fire)
            req_integ_q <= c_integ;
    end

    // frame pipeline: integration lands two frame starts after hand-off,
    // gains wait an extra frame only with compensation set
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pend_integ_q <= `ECL_RST_MANUAL_INTEG;
            app_integ_q <= `ECL_RST_MANUAL_INTEG;
            pend_s1_q <= 2'b00;
            pend_s2_q <= 2'b00;
            pend_fine_q <= `ECL_RST_FINE;
            app_s1_q <= 2'b00;
            app_s2_q <= 2'b00;
            app_fine_q <= `ECL_RST_FINE;
        end
        else if (frame_start)
        begin
            pend_integ_q <= req_integ_q;
            app_integ_q <= pend_integ_q;
            pend_s1_q <= loop_s1_q;
            pend_s2_q <= loop_s2_q;
            pend_fine_q <= loop_fine_q;
            app_s1_q <= lat_comp_q ? pend_s1_q : loop_s1_q;
            app_s2_q <= lat_comp_q ? pend_s2_q : loop_s2_q;
            app_fine_q <= lat_comp_q ? pend_fine_q : loop_fine_q;
        end
    end

    // sequencer-owned values, captured as they take effect
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            app_gran_q <= 16'h0000;
            app_clear_q <= 16'h0000;
            app_slope2_q <= 16'h0000;
            app_slope3_q <= 16'h0000;
            app_dual_q <= 1'b0;
            app_triple_q <= 1'b0;
        end
        else if (frame_start)
        begin
            if (global_shutter)
            begin
                app_gran_q <= seq_step_gran;
                app_clear_q <= seq_clear_len;
            end
            app_slope2_q <= second_slope_time;
            app_slope3_q <= third_slope_time;
            app_dual_q <= seq_dual_en;
            app_triple_q <= seq_triple_en;
        end
    end

    // analog codes to the front end follow what the image actually uses
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            amp1_gain_q <= 2'b00;
            amp2_gain_q <= 2'b00;
        end
        else
        begin
            amp1_gain_q <= app_s1_q;
            amp2_gain_q <= app_s2_q;
        end
    end

    // fine gain on samples: product of 10 bits by 5.7, saturated
    assign prod = {12'h000, pix_in} * {10'h000, app_fine_q};
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pix_out_q <= 10'h000;
            pix_out_valid_q <= 1'b0;
        end
        else
        begin
            pix_out_valid_q <= pix_in_valid;
            if (|prod[21:(`ECL_FINE_FRAC + 10)])
                pix_out_q <= `ECL_PIX_MAX;
            else
                pix_out_q <= prod[(`ECL_FINE_FRAC + 9):`ECL_FINE_FRAC];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_eval;
        frame_end && phase_q && aec_en_q;
    endsequence

    sequence s_ro_write;
        reg_wr && (reg_addr == `ECL_ADDR_LOOP_INTEG || reg_addr == `ECL_ADDR_APP_INTEG);
    endsequence

    property p_integ_floor;
        s_eval ##0 (integ_floor_q <= integ_ceil_q) |=> loop_integ_q >= $past(integ_floor_q);
    endproperty
    a_integ_floor: assert property (p_integ_floor) else $error("integration below floor");

    property p_integ_ceil;
        s_eval |=> loop_integ_q <= $past(integ_ceil_q);
    endproperty
    a_integ_ceil: assert property (p_integ_ceil) else $error("integration above ceiling");

    property p_stage1_range;
        s_eval |=> loop_s1_q <= $past(gain_ceil_q[1:0]);
    endproperty
    a_stage1_range: assert property (p_stage1_range) else $error("stage one above bound");

    property p_fine_range;
        s_eval |=> loop_fine_q <= $past(gain_ceil_q[15:4]);
    endproperty
    a_fine_range: assert property (p_fine_range) else $error("fine gain above bound");

    property p_every_other;
        frame_end && fired_last_q |-> !eval_fire;
    endproperty
    a_every_other: assert property (p_every_other) else $error("loop evaluated two frames running");

    property p_disabled_hold;
        !aec_en_q |=> $stable(loop_integ_q) && req_integ_q == $past(manual_integ_q);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("loop moved while disabled");

    property p_lat_comp;
        frame_start && lat_comp_q |=> app_fine_q == $past(pend_fine_q);
    endproperty
    a_lat_comp: assert property (p_lat_comp) else $error("gain not delayed a frame");

    property p_ro_write;
        s_ro_write |=> $stable(loop_integ_q) && $stable(app_integ_q) || $past(frame_start || eval_fire);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status changed by write");

    property p_applied_on_start;
        !frame_start |=> $stable(app_integ_q);
    endproperty
    a_applied_on_start: assert property (p_applied_on_start) else $error("applied status moved off frame start");

    property p_stats;
        stat_valid |=> pix_count_q == $past(stat_pixel_count) && mean_q == $past(stat_mean);
    endproperty
    a_stats: assert property (p_stats) else $error("statistics not captured");

endmodule : ecl_limits_status

// File: verification/test_ecl_limits_status.sv
`timescale 1ns/1ns
`include "ecl_defines.svh"
module test_ecl_limits_status
    import ecl_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_q;
    logic frame_end = 1'b0;
    logic frame_start = 1'b0;
    logic gain_up = 1'b0;
    logic gain_down = 1'b0;
    logic stat_valid = 1'b0;
    logic [15:0] stat_pixel_count = 16'h0000;
    logic [9:0] stat_mean = 10'h000;
    logic global_shutter = 1'b0;
    logic [15:0] seq_step_gran = 16'h0000;
    logic [15:0] seq_clear_len = 16'h0000;
    logic [15:0] second_slope_time = 16'h0000;
    logic [15:0] third_slope_time = 16'h0000;
    logic seq_dual_en = 1'b0;
    logic seq_triple_en = 1'b0;
    logic [9:0] pix_in = 10'h000;
    logic pix_in_valid = 1'b0;
    logic [9:0] pix_out_q;
    logic pix_out_valid_q;
    logic [15:0] req_integ_q;
    logic [1:0] amp1_gain_q;
    logic [1:0] amp2_gain_q;
    int bad_count = 0;
    int n_compared = 0;

    ecl_limits_status i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .frame_end(frame_end),
        .frame_start(frame_start), .gain_up(gain_up), .gain_down(gain_down), .stat_valid(stat_valid),
        .stat_pixel_count(stat_pixel_count), .stat_mean(stat_mean), .global_shutter(global_shutter),
        .seq_step_gran(seq_step_gran), .seq_clear_len(seq_clear_len),
        .second_slope_time(second_slope_time), .third_slope_time(third_slope_time),
        .seq_dual_en(seq_dual_en), .seq_triple_en(seq_triple_en), .pix_in(pix_in),
        .pix_in_valid(pix_in_valid), .pix_out_q(pix_out_q), .pix_out_valid_q(pix_out_valid_q),
        .req_integ_q(req_integ_q), .amp1_gain_q(amp1_gain_q), .amp2_gain_q(amp2_gain_q)
    );

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // strobes are driven on the falling edge so the rising edge sees settled values
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // read data is registered, so it is judged one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata_q, exp);
    endtask : rd

    task automatic pulse_fe();
        @(negedge core_clk);
        frame_end = 1'b1;
        @(negedge core_clk);
        frame_end = 1'b0;
    endtask : pulse_fe

    task automatic pulse_fs();
        @(negedge core_clk);
        frame_start = 1'b1;
        @(negedge core_clk);
        frame_start = 1'b0;
        @(negedge core_clk);
    endtask : pulse_fs

    // one evaluation needs two frame ends; the first of the pair must not move anything
    task automatic evaluate(input logic [15:0] old_integ);
        pulse_fe();
        rd(`ECL_ADDR_LOOP_INTEG, old_integ);
        pulse_fe();
    endtask : evaluate

    task automatic pix(input logic [9:0] p, input logic [9:0] exp);
        @(negedge core_clk);
        pix_in = p;
        pix_in_valid = 1'b1;
        @(negedge core_clk);
        pix_in_valid = 1'b0;
        chk({6'h00, pix_out_q}, {6'h00, exp});
        chk({15'h0000, pix_out_valid_q}, 16'h0001);
    endtask : pix

    task automatic t_reset();
        rd(`ECL_ADDR_INTEG_FLOOR, `ECL_RST_INTEG_FLOOR);
        rd(`ECL_ADDR_INTEG_CEIL, `ECL_RST_INTEG_CEIL);
        rd(`ECL_ADDR_GAIN_FLOOR, `ECL_RST_GAIN_FLOOR);
        rd(`ECL_ADDR_GAIN_CEIL, `ECL_RST_GAIN_CEIL);
        rd(`ECL_ADDR_LOOP_GAIN, 16'h0800);
        rd(`ECL_ADDR_APP_INTEG, 16'h0100);
        rd(8'h00, 16'h0000);
        chk(req_integ_q, 16'h0100);
    endtask : t_reset

    // climbing: integration first, then stage one, stage two, then fine gain up to its ceiling
    task automatic t_up();
        logic [15:0] integ_tab [7] = '{16'h0002, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003};
        logic [15:0] gain_tab [7] = '{16'h0800, 16'h0800, 16'h0801, 16'h0805, 16'h0885, 16'h0905, 16'h0905};
        logic [15:0] prev;
        wr(`ECL_ADDR_INTEG_CEIL, 16'h0003);
        wr(`ECL_ADDR_GAIN_CEIL, 16'h0905);
        wr(`ECL_ADDR_CTRL, 16'h0001);
        gain_up = 1'b1;
        prev = 16'h0001;
        for (int i = 0; i < 7; i++)
        begin
            evaluate(prev);
            rd(`ECL_ADDR_LOOP_INTEG, integ_tab[i]);
            rd(`ECL_ADDR_LOOP_GAIN, gain_tab[i]);
            chk(req_integ_q, integ_tab[i]);
            prev = integ_tab[i];
        end
        gain_up = 1'b0;
    endtask : t_up

    // applied values land on frame starts; rolling shutter keeps the old granularity
    task automatic t_applied();
        global_shutter = 1'b1;
        seq_step_gran = 16'h0011;
        seq_clear_len = 16'h0022;
        second_slope_time = 16'h0456;
        third_slope_time = 16'h0789;
        seq_dual_en = 1'b1;
        seq_triple_en = 1'b1;
        pulse_fs();
        pulse_fs();
        rd(`ECL_ADDR_APP_INTEG, 16'h0003);
        rd(`ECL_ADDR_APP_ANALOG, 16'h0021);
        rd(`ECL_ADDR_APP_FINE, 16'h3090);
        rd(`ECL_ADDR_APP_GRAN, 16'h0011);
        rd(`ECL_ADDR_APP_CLEAR, 16'h0022);
        rd(`ECL_ADDR_APP_SLOPE2, 16'h0456);
        rd(`ECL_ADDR_APP_SLOPE3, 16'h0789);
        chk({14'h0000, amp1_gain_q}, 16'h0001);
        chk({14'h0000, amp2_gain_q}, 16'h0001);
        pix(10'h100, 10'h120);
        pix(10'h3ff, 10'h3ff);
        global_shutter = 1'b0;
        seq_step_gran = 16'h0099;
        pulse_fs();
        rd(`ECL_ADDR_APP_GRAN, 16'h0011);
    endtask : t_applied

    // descending with priority inverted: fine, stage one, stage two, then integration to its floor
    task automatic t_down();
        logic [15:0] integ_tab [6] = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0002, 16'h0002};
        logic [15:0] gain_tab [6] = '{16'h0885, 16'h0805, 16'h0804, 16'h0800, 16'h0800, 16'h0800};
        logic [15:0] prev;
        wr(`ECL_ADDR_CTRL, 16'h0003);
        wr(`ECL_ADDR_INTEG_FLOOR, 16'h0002);
        gain_down = 1'b1;
        prev = 16'h0003;
        for (int i = 0; i < 6; i++)
        begin
            evaluate(prev);
            rd(`ECL_ADDR_LOOP_INTEG, integ_tab[i]);
            rd(`ECL_ADDR_LOOP_GAIN, gain_tab[i]);
            prev = integ_tab[i];
            if (i == 0)
            begin
                pulse_fs();
                rd(`ECL_ADDR_APP_FINE, 16'h3088);
                wr(`ECL_ADDR_LATENCY, 16'h2000);
            end
            if (i == 1)
            begin
                pulse_fs();
                rd(`ECL_ADDR_APP_FINE, 16'h3088);
                pulse_fs();
                rd(`ECL_ADDR_APP_FINE, 16'h3080);
                pix(10'h100, 10'h100);
            end
        end
        gain_down = 1'b0;
    endtask : t_down

    task automatic t_stats_ro();
        @(negedge core_clk);
        stat_pixel_count = 16'h1234;
        stat_mean = 10'h2a5;
        stat_valid = 1'b1;
        @(negedge core_clk);
        stat_valid = 1'b0;
        rd(`ECL_ADDR_PIX_COUNT, 16'h1234);
        rd(`ECL_ADDR_MEAN, 16'h02a5);
        wr(`ECL_ADDR_LOOP_INTEG, 16'hffff);
        wr(`ECL_ADDR_APP_GRAN, 16'hffff);
        wr(`ECL_ADDR_PIX_COUNT, 16'h0000);
        rd(`ECL_ADDR_LOOP_INTEG, 16'h0002);
        rd(`ECL_ADDR_APP_GRAN, 16'h0011);
        rd(`ECL_ADDR_PIX_COUNT, 16'h1234);
    endtask : t_stats_ro

    // with the loop off the manual time drives the sequencer and results freeze
    task automatic t_disable();
        wr(`ECL_ADDR_CTRL, 16'h0000);
        wr(`ECL_ADDR_MANUAL_INTEG, 16'h0123);
        @(negedge core_clk);
        chk(req_integ_q, 16'h0123);
        gain_up = 1'b1;
        evaluate(16'h0002);
        rd(`ECL_ADDR_LOOP_INTEG, 16'h0002);
        rd(`ECL_ADDR_LOOP_GAIN, 16'h0800);
        gain_up = 1'b0;
    endtask : t_disable

    // inverted priority on the way up: stage two moves before stage one
    task automatic t_pri_up();
        wr(`ECL_ADDR_CTRL, 16'h0003);
        gain_up = 1'b1;
        evaluate(16'h0002);
        rd(`ECL_ADDR_LOOP_INTEG, 16'h0003);
        evaluate(16'h0003);
        rd(`ECL_ADDR_LOOP_GAIN, 16'h0804);
        gain_up = 1'b0;
    endtask : t_pri_up

    initial
    begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_up();
        t_applied();
        t_down();
        t_stats_ro();
        t_disable();
        t_pri_up();
        results();
    end

    // the whole sequence needs under three hundred cycles; this cuts a hang short
    initial
    begin
        #200000;
        bad_count++;
        results();
    end
endmodule : test_ecl_limits_status
